/* File: rtl/fpc_pkg.sv */
package fpc_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] REG_STAT_OFS   = 8'h04;
    localparam logic [7:0] REG_IRQ_OFS    = 8'h08;
    localparam logic [7:0] REG_MASK_OFS   = 8'h0C;
    localparam logic [7:0] REG_LIMIT_OFS  = 8'h10;
    localparam logic [7:0] REG_SEL_OFS    = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_REMOTE_BIT  = 0;
    localparam int CTRL_LOCKOUT_BIT = 1;
    localparam int CTRL_GOREM_BIT   = 2;
    localparam int CTRL_IN_BIT      = 8;
    localparam int CTRL_OUT_LSB     = 16;
    localparam int CTRL_INWR_BIT    = 3;
    localparam int CTRL_OUTWR_BIT   = 4;
    localparam int IRQ_OVL_BIT      = 0;
    localparam int IRQ_TRIP_BIT     = 1;
    localparam int IRQ_LOCAL_BIT    = 2;
    localparam int IRQ_W            = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic       IN_RANGE_RST   = 1'b0;
    localparam logic [5:0] OUT_RANGE_RST  = 6'h01;
    localparam logic [2:0] MASK_RST       = 3'h0;
    localparam logic [7:0] COMP_LIM_RST   = 8'hFF;
    localparam logic [7:0] VIN_LIM_RST    = 8'hFF;

    // ****************************************
    // Band thresholds and timing
    // ****************************************
    localparam int FREQ_LOW_KHZ   = 100;
    localparam int FREQ_HIGH_KHZ  = 750;
    localparam int VIN_OVR_PCT    = 110;
    localparam int CLK_MHZ        = 250;
    localparam int DEBOUNCE_US    = 20;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int SCAN_US        = 1;
    localparam int SCAN_CYC       = SCAN_US * CLK_MHZ;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [19:0] freq_khz;
        logic [11:0] vin_pct;
        logic [7:0]  comp_v;
    } fpc_meas_t;

    typedef struct packed {
        logic       remote;
        logic       in_10v;
        logic [5:0] out_rng;
        logic [2:0] band;
    } fpc_stat_t;

    typedef enum logic [1:0] {
        FPC_LOCAL,
        FPC_REMOTE,
        FPC_LOCKED
    } fpc_ctl_t;

endpackage : fpc_pkg

/* File: rtl/fpc_debounce.sv */
`timescale 1ns/1ps
module fpc_debounce #(
    parameter int N      = 9,
    parameter int STABLE = 5000
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Raw pins and clean events
    input  wire logic [N-1:0] raw_i,
    output logic      [N-1:0] press_o
);

    // ****************************************
    // Per-button synchroniser and filter
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_btn
            logic        s1_reg;
            logic        s2_reg;
            logic        st_reg;
            logic        st_next;
            logic        p_reg;
            logic        p_next;
            logic [15:0] cnt_reg;
            logic [15:0] cnt_next;

            always_comb
            begin
                st_next  = st_reg;
                cnt_next = cnt_reg;
                p_next   = 1'b0;
                if (s2_reg == st_reg)
                begin
                    cnt_next = 16'h0000;
                end
                else if (cnt_reg == 16'(STABLE - 1))
                begin
                    // One event per settled press
                    cnt_next = 16'h0000;
                    st_next  = s2_reg;
                    p_next   = s2_reg;
                end
                else
                begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end

            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    st_reg  <= 1'b0;
                    p_reg   <= 1'b0;
                    cnt_reg <= 16'h0000;
                end
                else
                begin
                    s1_reg  <= raw_i[g];
                    s2_reg  <= s1_reg;
                    st_reg  <= st_next;
                    p_reg   <= p_next;
                    cnt_reg <= cnt_next;
                end
            end

            assign press_o[g] = p_reg;
        end
    endgenerate

endmodule : fpc_debounce

/* File: rtl/fpc_top.sv */
`timescale 1ns/1ps
module fpc_top #(
    parameter int DEBOUNCE_CYC = fpc_pkg::DEBOUNCE_CYC,
    parameter int SCAN_CYC     = fpc_pkg::SCAN_CYC
) (
    // Clock and reset
    input  wire logic             CORE_CLK_I,
    input  wire logic             RST_N_I,
    // APB slave
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [7:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    // Panel buttons and switch
    input  wire logic [1:0]       IN_BTN_I,
    input  wire logic [5:0]       OUT_BTN_I,
    input  wire logic             REMOTE_BTN_I,
    input  wire logic             OVERRIDE_SW_I,
    // Measurements
    input  wire fpc_pkg::fpc_meas_t MEAS_I,
    input  wire logic [15:0]      COMP_BCD_I,
    // Lamps and outputs
    output logic      [1:0]       IN_LAMP_O,
    output logic      [5:0]       OUT_LAMP_O,
    output logic      [2:0]       BAND_LAMP_O,
    output logic                  OVL_LAMP_O,
    output logic                  REMOTE_LAMP_O,
    output logic                  RELAY_TRIP_O,
    output logic                  SRQ_O,
    output logic                  IRQ_O,
    output logic      [6:0]       SEG_O,
    output logic      [3:0]       DIG_O
);

    // ****************************************
    // Buttons and synchronisers
    // ****************************************
    logic [8:0]  press;
    logic        ovs1_reg;
    logic        ovs2_reg;
    logic [39:0] ms1_reg;
    logic [39:0] ms2_reg;
    logic [15:0] bs1_reg;
    logic [15:0] bs2_reg;
    fpc_pkg::fpc_meas_t meas;

    fpc_debounce #(
        .N      (9),
        .STABLE (DEBOUNCE_CYC)
    ) u_deb (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .raw_i   ({REMOTE_BTN_I, OUT_BTN_I, IN_BTN_I}),
        .press_o (press)
    );

    // Measurements are slow levels; two-stage per bit is adequate
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ovs1_reg <= 1'b0;
            ovs2_reg <= 1'b0;
            ms1_reg  <= 40'h0;
            ms2_reg  <= 40'h0;
            bs1_reg  <= 16'h0;
            bs2_reg  <= 16'h0;
        end
        else
        begin
            ovs1_reg <= OVERRIDE_SW_I;
            ovs2_reg <= ovs1_reg;
            ms1_reg  <= MEAS_I;
            ms2_reg  <= ms1_reg;
            bs1_reg  <= COMP_BCD_I;
            bs2_reg  <= bs1_reg;
        end
    end
    assign meas = ms2_reg;

    // ****************************************
    // Control state
    // ****************************************
    fpc_pkg::fpc_ctl_t ctl_reg, ctl_next;
    logic        in_reg, in_next;
    logic [5:0]  out_reg, out_next;
    logic [2:0]  irq_reg, irq_next;
    logic [2:0]  mask_reg, mask_next;
    logic [7:0]  clim_reg, clim_next;
    logic [7:0]  vlim_reg, vlim_next;
    logic        trip_reg, trip_next;
    logic [2:0]  band_reg, band_next;
    logic        ovl_reg, ovl_next;
    logic        wr_acc;
    logic        rd_acc;
    logic        remote;
    logic        go_local;
    logic        ovl_now;
    logic        hard_ovl;
    logic [2:0]  irq_set;
    logic [7:0]  i_lim;
    logic [11:0] v_lim;

    assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I;
    assign remote = (ctl_reg != fpc_pkg::FPC_LOCAL);

    // ****************************************
    // Overload evaluation
    // ****************************************
    always_comb
    begin
        // The top current range (out_reg[5]) tolerates half the compliance
        i_lim = out_reg[5] ? (clim_reg >> 1) : clim_reg;
        // Input limit scaled in percent of selected range
        v_lim = 12'(fpc_pkg::VIN_OVR_PCT);
        band_next = 3'b001;
        if (meas.freq_khz > 20'(fpc_pkg::FREQ_HIGH_KHZ))
        begin
            band_next = 3'b100;
        end
        else if (meas.freq_khz >= 20'(fpc_pkg::FREQ_LOW_KHZ))
        begin
            band_next = 3'b010;
        end
        hard_ovl = meas.vin_pct > v_lim;
        ovl_now  = (meas.comp_v > i_lim)
                 | (meas.vin_pct > {4'h0, vlim_reg})
                 | (out_reg[5] & ~band_next[0])
                 | hard_ovl;
        ovl_next = ovl_now;
        // Trip latches until a new range is chosen while no overload is present
        trip_next = trip_reg;
        if (hard_ovl | (ovl_now & ~ovs2_reg))
        begin
            trip_next = 1'b1;
        end
        else if (!ovl_now && (in_next != in_reg || out_next != out_reg))
        begin
            trip_next = 1'b0;
        end
    end

    // ****************************************
    // Ranges, remote state, registers
    // ****************************************
    always_comb
    begin
        ctl_next  = ctl_reg;
        in_next   = in_reg;
        out_next  = out_reg;
        mask_next = mask_reg;
        clim_next = clim_reg;
        vlim_next = vlim_reg;
        go_local  = 1'b0;
        // Panel selections only in local operation
        if (!remote)
        begin
            if (press[0])
            begin
                in_next = 1'b0;
            end
            else if (press[1])
            begin
                in_next = 1'b1;
            end
            for (int k = 0; k < 6; k++)
            begin
                if (press[2+k])
                begin
                    out_next = 6'h01 << k;
                end
            end
        end
        if (press[8] && ctl_reg == fpc_pkg::FPC_REMOTE)
        begin
            ctl_next = fpc_pkg::FPC_LOCAL;
            go_local = 1'b1;
        end
        if (wr_acc)
        begin
            unique case (PADDR_I)
                fpc_pkg::REG_CTRL_OFS:
                begin
                    if (PWDATA_I[fpc_pkg::CTRL_GOREM_BIT])
                    begin
                        ctl_next = PWDATA_I[fpc_pkg::CTRL_LOCKOUT_BIT] ?
                                   fpc_pkg::FPC_LOCKED :
                                   (PWDATA_I[fpc_pkg::CTRL_REMOTE_BIT] ?
                                    fpc_pkg::FPC_REMOTE : fpc_pkg::FPC_LOCAL);
                    end
                    if (PWDATA_I[fpc_pkg::CTRL_INWR_BIT])
                    begin
                        in_next = PWDATA_I[fpc_pkg::CTRL_IN_BIT];
                    end
                    if (PWDATA_I[fpc_pkg::CTRL_OUTWR_BIT] &&
                        $onehot(PWDATA_I[fpc_pkg::CTRL_OUT_LSB +: 6]))
                    begin
                        out_next = PWDATA_I[fpc_pkg::CTRL_OUT_LSB +: 6];
                    end
                end
                fpc_pkg::REG_MASK_OFS:
                begin
                    mask_next = PWDATA_I[2:0];
                end
                fpc_pkg::REG_LIMIT_OFS:
                begin
                    clim_next = PWDATA_I[7:0];
                    vlim_next = PWDATA_I[15:8];
                end
                default:
                begin
                end
            endcase
        end
        // Set wins over write-one-to-clear
        irq_set = {go_local, trip_next & ~trip_reg, ovl_now & ~ovl_reg};
        irq_next = irq_reg;
        if (wr_acc && PADDR_I == fpc_pkg::REG_IRQ_OFS)
        begin
            irq_next = irq_reg & ~PWDATA_I[2:0];
        end
        irq_next = irq_next | irq_set;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctl_reg  <= fpc_pkg::FPC_LOCAL;
            in_reg   <= fpc_pkg::IN_RANGE_RST;
            out_reg  <= fpc_pkg::OUT_RANGE_RST;
            irq_reg  <= 3'h0;
            mask_reg <= fpc_pkg::MASK_RST;
            clim_reg <= fpc_pkg::COMP_LIM_RST;
            vlim_reg <= fpc_pkg::VIN_LIM_RST;
            trip_reg <= 1'b0;
            band_reg <= 3'b001;
            ovl_reg  <= 1'b0;
        end
        else
        begin
            ctl_reg  <= ctl_next;
            in_reg   <= in_next;
            out_reg  <= out_next;
            irq_reg  <= irq_next;
            mask_reg <= mask_next;
            clim_reg <= clim_next;
            vlim_reg <= vlim_next;
            trip_reg <= trip_next;
            band_reg <= band_next;
            ovl_reg  <= ovl_next;
        end
    end

    // ****************************************
    // APB read and output registers
    // ****************************************
    logic [31:0] rd_next;
    logic        err_next;

    always_comb
    begin
        rd_next  = 32'h0;
        err_next = 1'b0;
        if (rd_acc)
        begin
            unique case (PADDR_I)
                fpc_pkg::REG_CTRL_OFS:
                    rd_next = {10'h0, out_reg, 7'h0, in_reg,
                               6'h0, ctl_reg == fpc_pkg::FPC_LOCKED, remote};
                fpc_pkg::REG_STAT_OFS:
                    rd_next = {21'h0, remote, in_reg, out_reg, ovl_reg, trip_reg, 1'b0};
                fpc_pkg::REG_IRQ_OFS:
                    rd_next = {29'h0, irq_reg};
                fpc_pkg::REG_MASK_OFS:
                    rd_next = {29'h0, mask_reg};
                fpc_pkg::REG_LIMIT_OFS:
                    rd_next = {16'h0, vlim_reg, clim_reg};
                fpc_pkg::REG_SEL_OFS:
                    rd_next = {29'h0, band_reg};
                default:
                    err_next = 1'b1;
            endcase
        end
        else if (wr_acc)
        begin
            err_next = !(PADDR_I == fpc_pkg::REG_CTRL_OFS || PADDR_I == fpc_pkg::REG_IRQ_OFS
                      || PADDR_I == fpc_pkg::REG_MASK_OFS || PADDR_I == fpc_pkg::REG_LIMIT_OFS);
        end
    end

    // ****************************************
    // Seven-segment scan
    // ****************************************
    logic [15:0] scan_reg, scan_next;
    logic [1:0]  dig_reg, dig_next;
    logic [3:0]  nib;
    logic [6:0]  seg;

    always_comb
    begin
        scan_next = scan_reg + 16'h0001;
        dig_next  = dig_reg;
        if (scan_reg == 16'(SCAN_CYC - 1))
        begin
            scan_next = 16'h0000;
            dig_next  = dig_reg + 2'h1;
        end
        nib = bs2_reg[dig_reg*4 +: 4];
        unique case (nib)
            4'h0: seg = 7'h3F;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5B;
            4'h3: seg = 7'h4F;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6D;
            4'h6: seg = 7'h7D;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7F;
            4'h9: seg = 7'h6F;
            default: seg = 7'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            scan_reg      <= 16'h0;
            dig_reg       <= 2'h0;
            PRDATA_O      <= 32'h0;
            PREADY_O      <= 1'b0;
            PSLVERR_O     <= 1'b0;
            IN_LAMP_O     <= 2'b01;
            OUT_LAMP_O    <= fpc_pkg::OUT_RANGE_RST;
            BAND_LAMP_O   <= 3'b001;
            OVL_LAMP_O    <= 1'b0;
            REMOTE_LAMP_O <= 1'b0;
            RELAY_TRIP_O  <= 1'b0;
            SRQ_O         <= 1'b0;
            IRQ_O         <= 1'b0;
            SEG_O         <= 7'h0;
            DIG_O         <= 4'h0;
        end
        else
        begin
            scan_reg      <= scan_next;
            dig_reg       <= dig_next;
            PRDATA_O      <= rd_next;
            PREADY_O      <= PSEL_I & PENABLE_I & ~PREADY_O;
            PSLVERR_O     <= err_next & ~PREADY_O;
            IN_LAMP_O     <= {in_next, ~in_next};
            OUT_LAMP_O    <= out_next;
            BAND_LAMP_O   <= band_next;
            OVL_LAMP_O    <= ovl_next;
            REMOTE_LAMP_O <= ctl_next != fpc_pkg::FPC_LOCAL;
            RELAY_TRIP_O  <= trip_next;
            SRQ_O         <= irq_next[fpc_pkg::IRQ_OVL_BIT];
            IRQ_O         <= |(irq_next & mask_next);
            SEG_O         <= seg;
            DIG_O         <= 4'h1 << dig_reg;
        end
    end

endmodule : fpc_top

/* File: dv/fpc_top_asserts.sv */
`timescale 1ns/1ps
module fpc_top_asserts (
    // Clock and reset
    input wire logic               CORE_CLK_I,
    input wire logic               RST_N_I,
    // Watched pins
    input wire logic               PSEL_I,
    input wire logic               PENABLE_I,
    input wire logic               PREADY_O,
    input wire logic               PSLVERR_O,
    input wire logic               OVERRIDE_SW_I,
    input wire fpc_pkg::fpc_meas_t MEAS_I,
    input wire logic [1:0]         IN_LAMP_O,
    input wire logic [5:0]         OUT_LAMP_O,
    input wire logic [2:0]         BAND_LAMP_O,
    input wire logic               OVL_LAMP_O,
    input wire logic               REMOTE_LAMP_O,
    input wire logic               RELAY_TRIP_O,
    input wire logic               SRQ_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // ********
    // Sequences
    // ********
    sequence s_acc_start;
        $rose(PSEL_I && PENABLE_I);
    endsequence
    // Five cycles cover the input sync plus the lamp register
    sequence s_ovl_free;
        (OVL_LAMP_O && !OVERRIDE_SW_I)[*5];
    endsequence

    // ********
    // Properties
    // ********
    property p_in_onehot;
        $onehot(IN_LAMP_O);
    endproperty
    property p_out_onehot;
        $onehot(OUT_LAMP_O);
    endproperty
    property p_band_lo;
        (MEAS_I.freq_khz < 20'h64)[*5] |-> BAND_LAMP_O == 3'h1;
    endproperty
    property p_ready;
        s_acc_start |-> ##1 PREADY_O;
    endproperty
    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    property p_err;
        PSLVERR_O |-> PREADY_O;
    endproperty
    property p_trip_free;
        s_ovl_free |-> RELAY_TRIP_O;
    endproperty
    property p_trip_ovr;
        (OVERRIDE_SW_I && MEAS_I.vin_pct <= 12'h6E)[*6] |-> !$rose(RELAY_TRIP_O);
    endproperty
    property p_ovl_srq;
        $rose(OVL_LAMP_O) |-> ##[0:2] SRQ_O;
    endproperty
    property p_remote_hold;
        (REMOTE_LAMP_O && !PSEL_I)[*3] |=> $stable({IN_LAMP_O, OUT_LAMP_O});
    endproperty

    a_in_onehot: assert property (p_in_onehot)
        else $error("input lamps not one-hot");
    a_out_onehot: assert property (p_out_onehot)
        else $error("output lamps not one-hot");
    a_band_lo: assert property (p_band_lo)
        else $error("low band lamp wrong");
    a_ready: assert property (p_ready)
        else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err: assert property (p_err)
        else $error("pslverr without pready");
    a_trip_free: assert property (p_trip_free)
        else $error("overload did not trip");
    a_trip_ovr: assert property (p_trip_ovr)
        else $error("tripped under override");
    a_ovl_srq: assert property (p_ovl_srq)
        else $error("no service request on overload");
    a_remote_hold: assert property (p_remote_hold)
        else $error("panel range changed in remote");
endmodule : fpc_top_asserts

bind fpc_top fpc_top_asserts i_fpc_top_asserts (
    .CORE_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O,
    .OVERRIDE_SW_I, .MEAS_I, .IN_LAMP_O, .OUT_LAMP_O, .BAND_LAMP_O,
    .OVL_LAMP_O, .REMOTE_LAMP_O, .RELAY_TRIP_O, .SRQ_O
);

/* File: dv/fpc_panel_model.sv */
`timescale 1ns/1ps
module fpc_panel_model (
    // Clock
    input  wire logic          clk_i,
    // Buttons and switch
    output logic [1:0]         in_btn_o,
    output logic [5:0]         out_btn_o,
    output logic               rem_btn_o,
    output logic               ovr_o,
    // Measurements
    output fpc_pkg::fpc_meas_t meas_o,
    output logic [15:0]        bcd_o
);
    initial
    begin
        in_btn_o  = '0;
        out_btn_o = '0;
        rem_btn_o = '0;
        ovr_o     = '0;
        meas_o    = '0;
        bcd_o     = '0;
    end

    // Contacts chatter for four cycles before a firm hold
    task automatic press(input int grp, input int idx);
        logic v;
        for (int i = 0; i < 26; i++)
        begin
            v = (i < 4) ? (i % 2 == 0) : (i < 16);
            @(posedge clk_i);
            case (grp)
                0: in_btn_o[idx] <= v;
                1: out_btn_o[idx] <= v;
                default: rem_btn_o <= v;
            endcase
        end
    endtask : press

    // Values pass a two-stage sync, so allow them to settle
    task automatic set(input logic [19:0] f, input logic [11:0] v,
                       input logic [7:0] c, input logic o, input logic [15:0] b);
        @(posedge clk_i);
        meas_o <= '{freq_khz: f, vin_pct: v, comp_v: c};
        ovr_o  <= o;
        bcd_o  <= b;
        repeat (8) @(posedge clk_i);
    endtask : set
endmodule : fpc_panel_model

/* File: dv/tb_fpc_top.sv */
`timescale 1ns/1ps
module tb_fpc_top;
    logic               clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdat;
    logic [1:0]         in_btn, in_lamp;
    logic [5:0]         out_btn, out_lamp;
    logic               rem_btn, ovr, ovl, rem_lamp, trip, srq, irq, rerr;
    fpc_pkg::fpc_meas_t meas;
    logic [15:0]        bcd;
    logic [2:0]         band;
    logic [6:0]         seg;
    logic [3:0]         dig;
    int                 bad_count = 0;
    int                 num_checks = 0;
    int                 cyc = 0;

    fpc_top #(
        .DEBOUNCE_CYC (4),
        .SCAN_CYC     (4)
    ) i_fpc_top (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .IN_BTN_I(in_btn),
        .OUT_BTN_I(out_btn), .REMOTE_BTN_I(rem_btn), .OVERRIDE_SW_I(ovr),
        .MEAS_I(meas), .COMP_BCD_I(bcd), .IN_LAMP_O(in_lamp), .OUT_LAMP_O(out_lamp),
        .BAND_LAMP_O(band), .OVL_LAMP_O(ovl), .REMOTE_LAMP_O(rem_lamp),
        .RELAY_TRIP_O(trip), .SRQ_O(srq), .IRQ_O(irq), .SEG_O(seg), .DIG_O(dig)
    );

    fpc_panel_model i_fpc_panel_model (
        .clk_i(clk), .in_btn_o(in_btn), .out_btn_o(out_btn), .rem_btn_o(rem_btn),
        .ovr_o(ovr), .meas_o(meas), .bcd_o(bcd)
    );

    always #2 clk = ~clk;

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        check("pready", 32'(pready), 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // Let register effects reach the lamps
        repeat (2) @(posedge clk);
    endtask : apb

    task automatic t_reset();
        check("in lamp", 32'(in_lamp), 32'h1);
        check("out lamp", 32'(out_lamp), 32'h1);
        check("remote lamp", 32'(rem_lamp), 32'h0);
        apb(1'h0, fpc_pkg::REG_LIMIT_OFS, 32'h0);
        check("limit", rdat, 32'h0000FFFF);
        apb(1'h0, 8'h20, 32'h0);
        check("unmapped", 32'(rerr), 32'h1);
    endtask : t_reset

    task automatic t_ranges();
        i_fpc_panel_model.press(0, 1);
        check("in lamp", 32'(in_lamp), 32'h2);
        i_fpc_panel_model.press(0, 0);
        check("in lamp", 32'(in_lamp), 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            i_fpc_panel_model.press(1, i);
            check("out lamp", 32'(out_lamp), 32'h1 << i);
        end
        i_fpc_panel_model.press(1, 0);
        check("out lamp", 32'(out_lamp), 32'h1);
    endtask : t_ranges

    task automatic t_band();
        logic [19:0] fq [4];
        logic [2:0]  ex [4];
        fq = '{20'h63, 20'h64, 20'h2EE, 20'h2EF};
        ex = '{3'h1, 3'h2, 3'h2, 3'h4};
        for (int k = 0; k < 4; k++)
        begin
            i_fpc_panel_model.set(fq[k], 12'h0, 8'h0, 1'h0, 16'h0);
            check("band", 32'(band), 32'(ex[k]));
        end
    endtask : t_band

    task automatic t_ovl();
        apb(1'h1, fpc_pkg::REG_LIMIT_OFS, 32'h0000FF80);
        i_fpc_panel_model.set(20'h32, 12'h64, 8'h90, 1'h0, 16'h0);
        check("overload lamp", 32'(ovl), 32'h1);
        check("trip", 32'(trip), 32'h1);
        check("srq", 32'(srq), 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'h0, fpc_pkg::REG_IRQ_OFS, 32'h0);
        check("irq status", rdat & 32'h3, 32'h3);
        apb(1'h1, fpc_pkg::REG_MASK_OFS, 32'h7);
        check("irq", 32'(irq), 32'h1);
        i_fpc_panel_model.set(20'h32, 12'h64, 8'h10, 1'h0, 16'h0);
        check("overload lamp", 32'(ovl), 32'h0);
        check("trip held", 32'(trip), 32'h1);
        i_fpc_panel_model.press(1, 1);
        check("trip cleared", 32'(trip), 32'h0);
        apb(1'h1, fpc_pkg::REG_IRQ_OFS, 32'h7);
        check("srq", 32'(srq), 32'h0);
        check("irq", 32'(irq), 32'h0);
    endtask : t_ovl

    task automatic t_ovr();
        i_fpc_panel_model.press(1, 5);
        i_fpc_panel_model.set(20'hC8, 12'h6E, 8'h10, 1'h1, 16'h0);
        check("overload lamp", 32'(ovl), 32'h1);
        check("no trip", 32'(trip), 32'h0);
        check("srq", 32'(srq), 32'h1);
        i_fpc_panel_model.set(20'hC8, 12'h6F, 8'h10, 1'h1, 16'h0);
        check("hard trip", 32'(trip), 32'h1);
        i_fpc_panel_model.set(20'h32, 12'h64, 8'h10, 1'h0, 16'h0);
        i_fpc_panel_model.press(1, 0);
        apb(1'h1, fpc_pkg::REG_IRQ_OFS, 32'h7);
    endtask : t_ovr

    task automatic t_remote();
        apb(1'h1, fpc_pkg::REG_CTRL_OFS, 32'h5);
        check("remote lamp", 32'(rem_lamp), 32'h1);
        i_fpc_panel_model.press(0, 1);
        check("in lamp", 32'(in_lamp), 32'h1);
        i_fpc_panel_model.press(1, 3);
        check("out lamp", 32'(out_lamp), 32'h1);
        i_fpc_panel_model.press(2, 0);
        check("remote lamp", 32'(rem_lamp), 32'h0);
        apb(1'h0, fpc_pkg::REG_IRQ_OFS, 32'h0);
        check("local event", rdat & 32'h4, 32'h4);
        apb(1'h1, fpc_pkg::REG_CTRL_OFS, 32'h7);
        i_fpc_panel_model.press(2, 0);
        check("locked lamp", 32'(rem_lamp), 32'h1);
        apb(1'h1, fpc_pkg::REG_CTRL_OFS, 32'h4);
        check("remote lamp", 32'(rem_lamp), 32'h0);
    endtask : t_remote

    task automatic t_disp();
        logic [6:0] st [4];
        logic [3:0] seen;
        st = '{7'h66, 7'h4F, 7'h5B, 7'h06};
        seen = 4'h0;
        i_fpc_panel_model.set(20'h32, 12'h64, 8'h10, 1'h0, 16'h1234);
        repeat (40)
        begin
            @(posedge clk);
            seen = seen | dig;
            for (int k = 0; k < 4; k++)
                if (dig === 4'h1 << k)
                    check("segments", 32'(seg), 32'(st[k]));
        end
        check("digits", 32'(seen), 32'hF);
    endtask : t_disp

    initial
    begin
        clk     = 1'h0;
        rst_n   = 1'h0;
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_reset();
        t_ranges();
        t_band();
        t_ovl();
        t_ovr();
        t_remote();
        t_disp();
        final_report();
    end
endmodule : tb_fpc_top
